//--- logic/psb_burst_cnt.sv
// Two-bit wrapping burst counter over the lowest address bits.
// Assumes load and advance are never high in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module psb_burst_cnt
  import psb_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Control.
  input  wire logic       load_in,
  input  wire logic       adv_in,
  input  wire logic       interleave_in,
  input  wire logic [1:0] base_in,
  // Low address bits.
  output logic      [1:0] cur_lo_out,
  output logic      [1:0] nxt_lo_out
);

  logic [1:0] base_ff;
  logic [1:0] cnt_ff;
  wire  [1:0] cnt_inc;

  function automatic logic [1:0] map_lo(input logic [1:0] b, input logic [1:0] c, input logic il);
    map_lo = il ? (b ^ c) : 2'(b + c);
  endfunction : map_lo

  assign cnt_inc    = 2'(cnt_ff + 2'h1);
  assign cur_lo_out = map_lo(base_ff, cnt_ff, interleave_in);    // [R13]
  assign nxt_lo_out = map_lo(base_ff, cnt_inc, interleave_in);   // [R13]

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      base_ff <= BURST_CNT_RST;
      cnt_ff  <= BURST_CNT_RST;
    end else if (load_in) begin
      base_ff <= base_in;
      cnt_ff  <= BURST_CNT_RST;
    end else if (adv_in) begin
      cnt_ff  <= cnt_inc;   // [R13]
    end
  end

endmodule : psb_burst_cnt
`default_nettype wire

//--- logic/psb_pkg.sv
// Shared constants and types for the pipelined burst SRAM cycle decode.
// Assumes one 40 MHz clock; every user of it imports the whole package.
package psb_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int LANES         = 4;
  localparam int LANE_W        = 8;
  localparam int DATA_W        = LANES * LANE_W;
  localparam int ADDR_W        = 21;

  // Sleep entry and exit time, in clock periods, and its count of cycles.
  localparam int SLEEP_TIME_CYC = 2;
  localparam int SLEEP_CYC      = (SLEEP_TIME_CYC * CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_CYC - 1);

  // Values after reset.
  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;

  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_DESEL,
    CYC_START_PROC,
    CYC_START_CTRL,
    CYC_CONT,
    CYC_SUSP
  } psb_cyc_t;

  typedef enum logic [1:0] {
    SLP_RUN,
    SLP_ENTER,
    SLP_DOWN,
    SLP_EXIT
  } psb_slp_t;

endpackage : psb_pkg

//--- logic/psb_sram_decode.sv
// Synchronous cycle decode and data pin control of a pipelined burst SRAM.
// Assumes an array core outside that answers core_rdata_in in the same
// cycle that core_rd_out is high, and a pad ring that resolves the enables.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] Deselect combinations tristate data, no address used.
// [R2] Sleep request forces power down and tristate.
// [R3] Processor strobe with selects begins read burst.
// [R4] Processor strobe start cycle never writes.
// [R5] Controller strobe start reads or writes externally.
// [R6] Advance low continues burst at next address.
// [R7] Advance high suspends burst at current address.
// [R8] Global or lane byte write gives write.
// [R9] No write enables active gives read.
// [R10] Output enable gates read data asynchronously.
// [R11] Write cycles mask output enable internally.
// [R12] Master raises output enable before writes.
// [R13] Two-bit burst counter, interleaved or linear.
// [R14] Processor strobe write completes on second clock.
// [R15] First cycle out of deselect stays tristate.
// [R16] Sleep entry and exit take two clocks.
// [R17] Read data registered one clock after address.
module psb_sram_decode
  import psb_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  // Clock and reset.
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Selects and strobes.
  input  wire logic              chip_sel_primary_n_in,
  input  wire logic              chip_sel_expand_hi_in,
  input  wire logic              chip_sel_expand_lo_n_in,
  input  wire logic              proc_addr_strobe_n_in,
  input  wire logic              ctrl_addr_strobe_n_in,
  input  wire logic              burst_advance_n_in,
  input  wire logic              burst_mode_in,
  input  wire logic [AW-1:0]     addr_in,
  // Write controls.
  input  wire logic              global_write_n_in,
  input  wire logic              byte_write_en_n_in,
  input  wire logic [LANES-1:0]  lane_write_n_in,
  // Asynchronous controls.
  input  wire logic              out_en_n_in,
  input  wire logic              sleep_request_in,
  // Data pins.
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n_out,
  input  wire logic [LANES-1:0]  parity_io_in,
  output logic      [LANES-1:0]  parity_io_out,
  output logic                   parity_io_oe_n_out,
  // Array core side.
  output logic      [AW-1:0]     core_addr_out,
  output logic                   core_rd_out,
  output logic      [LANES-1:0]  core_lane_we_out,
  output logic      [DATA_W-1:0] core_wdata_out,
  output logic      [LANES-1:0]  core_wpar_out,
  input  wire logic [DATA_W-1:0] core_rdata_in,
  input  wire logic [LANES-1:0]  core_rpar_in,
  // Status.
  output logic                   sleep_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode.

  logic              active_ff;
  logic              pend_rd_ff;
  logic              rd_drv_ff;
  logic [DATA_W-1:0] dq_ff;
  logic [LANES-1:0]  par_ff;
  logic [AW-1:0]     core_addr_ff;
  logic              core_rd_ff;
  logic [LANES-1:0]  core_we_ff;
  logic [DATA_W-1:0] core_wdata_ff;
  logic [LANES-1:0]  core_wpar_ff;
  psb_slp_t          slp_ff;
  psb_slp_t          nxt_slp;
  logic [1:0]        slp_cnt_ff;
  logic [1:0]        nxt_slp_cnt;
  logic              sleep_ff;

  wire             awake;
  wire             exp_ok;
  wire             all_sel;
  wire             desel;
  wire             start_proc;
  wire             start_ctrl;
  wire             follow;
  wire             cont;
  wire             susp;
  wire             is_start;
  wire             do_write;
  wire             do_read;
  wire [LANES-1:0] lane_we;
  wire             write_n;
  wire [1:0]       cur_lo;
  wire [1:0]       nxt_lo;
  wire [AW-1:0]    nxt_addr;
  psb_cyc_t        cyc;

  assign awake      = (slp_ff == SLP_RUN) & ~sleep_request_in;   // [R16]
  assign exp_ok     = chip_sel_expand_hi_in & ~chip_sel_expand_lo_n_in;
  assign all_sel    = ~chip_sel_primary_n_in & exp_ok;
  assign desel      = (chip_sel_primary_n_in & ~ctrl_addr_strobe_n_in) |
                      (~chip_sel_primary_n_in & ~exp_ok &
                       (~proc_addr_strobe_n_in | ~ctrl_addr_strobe_n_in));   // [R1]
  assign start_proc = all_sel & ~proc_addr_strobe_n_in;   // [R3]
  assign start_ctrl = all_sel & proc_addr_strobe_n_in & ~ctrl_addr_strobe_n_in;   // [R5]
  assign follow     = active_ff & ctrl_addr_strobe_n_in &
                      (proc_addr_strobe_n_in | chip_sel_primary_n_in);
  assign cont       = follow & ~burst_advance_n_in;   // [R6]
  assign susp       = follow & burst_advance_n_in;    // [R7]

  assign cyc = ~awake     ? CYC_IDLE :
               desel      ? CYC_DESEL :
               start_proc ? CYC_START_PROC :
               start_ctrl ? CYC_START_CTRL :
               cont       ? CYC_CONT :
               susp       ? CYC_SUSP : CYC_IDLE;

  assign is_start = (cyc == CYC_START_PROC) | (cyc == CYC_START_CTRL);
  // A processor strobe start is always a read; writes follow it.
  assign do_write = ~write_n & ((cyc == CYC_START_CTRL) | (cyc == CYC_CONT) |
                                (cyc == CYC_SUSP));   // [R4] [R14]
  assign do_read  = (cyc == CYC_START_PROC) | (write_n & ((cyc == CYC_START_CTRL) |
                    (cyc == CYC_CONT) | (cyc == CYC_SUSP)));   // [R3]
  assign nxt_addr = is_start ? addr_in :
                    {core_addr_ff[AW-1:2], (cyc == CYC_CONT) ? nxt_lo : cur_lo};   // [R6] [R7]

  psb_write_decode u_wdec (
    .global_write_n_in  (global_write_n_in),
    .byte_write_en_n_in (byte_write_en_n_in),
    .lane_write_n_in    (lane_write_n_in),
    .lane_we_out        (lane_we),
    .write_n_out        (write_n)
  );

  psb_burst_cnt u_cnt (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .load_in       (is_start),
    .adv_in        (cyc == CYC_CONT),
    .interleave_in (burst_mode_in),
    .base_in       (addr_in[1:0]),
    .cur_lo_out    (cur_lo),
    .nxt_lo_out    (nxt_lo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access and output pipeline.

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_ff  <= 1'b0;
      pend_rd_ff <= 1'b0;
      core_rd_ff <= 1'b0;
      core_we_ff <= '0;
    end else begin
      active_ff  <= is_start | (active_ff & awake & ~desel);   // [R1]
      pend_rd_ff <= do_read;
      core_rd_ff <= do_read;                                  // [R3]
      core_we_ff <= do_write ? lane_we : '0;                  // [R8]
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      core_addr_ff  <= '0;
      core_wdata_ff <= '0;
      core_wpar_ff  <= '0;
    end else if (do_read | do_write) begin
      core_addr_ff  <= nxt_addr;
      core_wdata_ff <= dq_in;
      core_wpar_ff  <= parity_io_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_drv_ff <= 1'b0;
    end else if (~awake | (cyc == CYC_DESEL) | do_write) begin
      rd_drv_ff <= 1'b0;   // [R1] [R2] [R11]
    end else if (pend_rd_ff) begin
      rd_drv_ff <= 1'b1;   // [R15]
    end
  end

  // Read data is registered even when the drivers are being switched off.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dq_ff  <= '0;
      par_ff <= '0;
    end else if (pend_rd_ff) begin
      dq_ff  <= core_rdata_in;   // [R17]
      par_ff <= core_rpar_in;
    end
  end

  // Output enable and sleep act on the pads without the clock.
  assign dq_oe_n_out        = ~(rd_drv_ff & ~out_en_n_in & ~sleep_request_in);   // [R10] [R2]
  assign parity_io_oe_n_out = dq_oe_n_out;   // [R10]
  assign dq_out             = dq_ff;
  assign parity_io_out      = par_ff;
  assign core_addr_out      = core_addr_ff;
  assign core_rd_out        = core_rd_ff;
  assign core_lane_we_out   = core_we_ff;
  assign core_wdata_out     = core_wdata_ff;
  assign core_wpar_out      = core_wpar_ff;
  assign sleep_out          = sleep_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencing.

  always_comb begin
    nxt_slp     = slp_ff;
    nxt_slp_cnt = slp_cnt_ff;
    unique case (slp_ff)
      SLP_RUN: begin
        if (sleep_request_in) begin
          nxt_slp     = SLP_ENTER;
          nxt_slp_cnt = 2'h1;
        end
      end
      SLP_ENTER: begin
        if (!sleep_request_in) begin
          nxt_slp     = SLP_EXIT;
          nxt_slp_cnt = 2'h1;
        end else if (slp_cnt_ff >= SLEEP_CNT_LAST) begin
          nxt_slp     = SLP_DOWN;   // [R16]
        end else begin
          nxt_slp_cnt = 2'(slp_cnt_ff + 2'h1);
        end
      end
      SLP_DOWN: begin
        if (!sleep_request_in) begin
          nxt_slp     = SLP_EXIT;
          nxt_slp_cnt = 2'h1;
        end
      end
      SLP_EXIT: begin
        if (sleep_request_in) begin
          nxt_slp     = SLP_ENTER;
          nxt_slp_cnt = 2'h1;
        end else if (slp_cnt_ff >= SLEEP_CNT_LAST) begin
          nxt_slp     = SLP_RUN;    // [R16]
        end else begin
          nxt_slp_cnt = 2'(slp_cnt_ff + 2'h1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      slp_ff     <= SLP_RUN;
      slp_cnt_ff <= SLEEP_CNT_RST;
      sleep_ff   <= 1'b0;
    end else begin
      slp_ff     <= nxt_slp;
      slp_cnt_ff <= nxt_slp_cnt;
      sleep_ff   <= (nxt_slp == SLP_DOWN) | (nxt_slp == SLP_EXIT);   // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_proc_start;
    awake && start_proc && !desel;
  endsequence

  sequence s_clean_follow;
    awake && !desel && !do_write;
  endsequence

  sequence s_sleep_in;
    (slp_ff == SLP_RUN) && sleep_request_in ##1 sleep_request_in;
  endsequence

  a_desel_tristate: assert property ((cyc == CYC_DESEL) |=> dq_oe_n_out)   // [R1]
    else $error("data pins driven after a deselect cycle");
  a_sleep_tristate: assert property (sleep_request_in |-> dq_oe_n_out && parity_io_oe_n_out)   // [R2]
    else $error("data pins driven during sleep request");
  a_proc_read: assert property (s_proc_start |=> core_rd_out && core_lane_we_out == '0)   // [R3]
    else $error("processor strobe start did not read");
  a_proc_two_clk: assert property (s_proc_start ##1 (awake && susp && !desel && !write_n)
                                   |=> core_lane_we_out == $past(lane_we))   // [R14]
    else $error("write after processor strobe start not taken");
  a_ctrl_write: assert property ((cyc == CYC_START_CTRL) && !write_n
                                 |=> !core_rd_out && core_addr_out == $past(addr_in))   // [R5]
    else $error("controller strobe write missed");
  a_cont_addr: assert property ((cyc == CYC_CONT)
                                |=> core_addr_out[AW-1:2] == $past(core_addr_out[AW-1:2]))   // [R6]
    else $error("continue burst left the burst block");
  a_susp_addr: assert property ((cyc == CYC_SUSP) |=> core_addr_out == $past(core_addr_out))   // [R7]
    else $error("suspend burst changed the address");
  a_write_lanes: assert property (do_write && !global_write_n_in |=> core_lane_we_out == '1)   // [R8]
    else $error("global write did not enable all lanes");
  a_read_decode: assert property ((cyc == CYC_START_CTRL) && global_write_n_in &&
                                  (byte_write_en_n_in || lane_write_n_in == '1)
                                  |=> core_rd_out && core_lane_we_out == '0)   // [R9]
    else $error("no write enable yet a write was issued");
  a_oe_gate: assert property (out_en_n_in |-> dq_oe_n_out)   // [R10]
    else $error("data pins driven with output enable high");
  a_write_mask: assert property (do_write |=> dq_oe_n_out)   // [R11]
    else $error("data pins driven in a write cycle");
  a_first_tristate: assert property (s_proc_start and !active_ff |=> !rd_drv_ff)   // [R15]
    else $error("first cycle out of deselect was driven");
  a_sleep_entry: assert property (s_sleep_in |=> sleep_out ##1 (!sleep_request_in || sleep_out))   // [R16]
    else $error("sleep not entered after two clocks");
  a_read_pipe: assert property (s_proc_start ##1 s_clean_follow
                                |=> rd_drv_ff && dq_out == $past(core_rdata_in))   // [R17]
    else $error("read data not presented one clock after address");

endmodule : psb_sram_decode
`default_nettype wire

//--- logic/psb_write_decode.sv
// Decode of the global, byte-enable and per-lane write inputs.
// Assumes inputs come straight from the pins; the caller registers the decoded result.
`timescale 1ns/1ps
`default_nettype none
module psb_write_decode
  import psb_pkg::*;
(
  // Write inputs.
  input  wire logic             global_write_n_in,
  input  wire logic             byte_write_en_n_in,
  input  wire logic [LANES-1:0] lane_write_n_in,
  // Decoded result.
  output logic      [LANES-1:0] lane_we_out,
  output logic                  write_n_out
);

  wire [LANES-1:0] all_lanes;
  wire [LANES-1:0] sel_lanes;

  assign all_lanes   = {LANES{~global_write_n_in}};
  assign sel_lanes   = {LANES{~byte_write_en_n_in}} & ~lane_write_n_in;
  assign lane_we_out = all_lanes | sel_lanes;   // [R8]
  assign write_n_out = ~|lane_we_out;           // [R9]

endmodule : psb_write_decode
`default_nettype wire

//--- verification/psb_core_model.sv
// Behavioural array core answering the decode block's read and write pulses.
// Assumes read data is wanted combinationally in the cycle of the read pulse.
`timescale 1ns/1ps
`default_nettype none
module psb_core_model
  import psb_pkg::*;
(
  // Clock.
  input  wire logic              clk_in,
  // Requests from the decode block.
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              rd_in,
  input  wire logic [LANES-1:0]  we_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [LANES-1:0]  wpar_in,
  // Answer.
  output logic      [DATA_W-1:0] rdata_out,
  output logic      [LANES-1:0]  rpar_out
);
  logic [DATA_W+LANES-1:0] mem_ff [logic [ADDR_W-1:0]];
  logic [DATA_W+LANES-1:0] last_ff = '0;
  logic [DATA_W+LANES-1:0] word;

  ////////////////////////////////////////////////////////////////////////////
  // Outside a read the answer is the inverse of the last word, never held.
  always @* word = (rd_in && mem_ff.exists(addr_in)) ? mem_ff[addr_in] : ~last_ff;
  assign {rpar_out, rdata_out} = word;

  always @(posedge clk_in) begin
    for (int k = 0; k < LANES; k++) begin
      if (we_in[k]) begin
        mem_ff[addr_in][8*k +: 8] = wdata_in[8*k +: 8];
        mem_ff[addr_in][DATA_W+k] = wpar_in[k];
      end
    end
    last_ff <= word;
  end
endmodule : psb_core_model
`default_nettype wire

//--- verification/test_psb_sram_decode.sv
// Self-checking bench of the pipelined burst SRAM cycle decode.
// Assumes the array core model answers reads in the cycle of the pulse.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module test_psb_sram_decode;
  import psb_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1;
  logic n1 = 1'b1, sel = 1'b0, ps = 1'b1, cs = 1'b1, burst_advance_n = 1'b1, md = 1'b0;
  logic gw = 1'b1, bw = 1'b1, oe = 1'b1, zz = 1'b0, slp = 1'b0;
  logic [LANES-1:0] lw = '1, pi = '0, pa_o, cwe, cwp, rp;
  logic [ADDR_W-1:0] a = '0, ca, bs, b;
  logic [DATA_W-1:0] dq = '0, dq_o, cwd, rd;
  logic oe_o, poe_o, crd, so, drv = 1'b0, prd = 1'b0;
  logic [DATA_W+LANES-1:0] pw, mem [logic [ADDR_W-1:0]];
  int act = 0, cnt = 0, n, miscompares = 0, samples_checked = 0;
  integer seed;

  ////////////////////////////////////////////////////////////////////////////
  always #12.5 clk_in = ~clk_in;

  psb_sram_decode psb_sram_decode_i (.clk_in(clk_in), .rst_in(rst_in),
    .chip_sel_primary_n_in(n1), .chip_sel_expand_hi_in(sel), .chip_sel_expand_lo_n_in(!sel),
    .proc_addr_strobe_n_in(ps), .ctrl_addr_strobe_n_in(cs), .burst_advance_n_in(burst_advance_n),
    .burst_mode_in(md), .addr_in(a), .global_write_n_in(gw), .byte_write_en_n_in(bw),
    .lane_write_n_in(lw), .out_en_n_in(oe), .sleep_request_in(zz), .dq_in(dq), .dq_out(dq_o),
    .dq_oe_n_out(oe_o), .parity_io_in(pi), .parity_io_out(pa_o), .parity_io_oe_n_out(poe_o),
    .core_addr_out(ca), .core_rd_out(crd), .core_lane_we_out(cwe), .core_wdata_out(cwd),
    .core_wpar_out(cwp), .core_rdata_in(rd), .core_rpar_in(rp), .sleep_out(so));

  psb_core_model psb_core_model_i (.clk_in(clk_in), .addr_in(ca), .rd_in(crd), .we_in(cwe),
    .wdata_in(cwd), .wpar_in(cwp), .rdata_out(rd), .rpar_out(rp));

  ////////////////////////////////////////////////////////////////////////////
  // One bus request per edge; the request taken at this edge is modelled and checked.
  task automatic step(input logic n1v, sv, pv, cv, av, gv, bv, input logic [3:0] lv,
                      input logic [ADDR_W-1:0] adr, input logic ov);
    logic ds, st, wr, rdn;
    logic [3:0] we;
    logic [DATA_W+LANES-1:0] dw;
    @(posedge clk_in);
    ds = (n1 && !cs) || (!n1 && !sel && !(ps && cs));
    st = !n1 && sel && !(ps && cs);
    we = !gw ? 4'hf : (!bw ? ~lw : 4'h0);
    rdn = 1'b0;
    wr = 1'b0;
    if (ds) act = 0;
    else if (st) begin
      act = 1;
      bs = a;
      cnt = 0;
      rdn = !ps || we == 4'h0;
      wr = !rdn;
    end else if (act == 1 && cs && (ps || n1)) begin
      cnt += !burst_advance_n;
      rdn = we == 4'h0;
      wr = !rdn;
    end
    b = {bs[ADDR_W-1:2], md ? bs[1:0] ^ 2'(cnt) : bs[1:0] + 2'(cnt)};
    dw = {pi, dq};
    for (int k = 0; k < LANES; k++) begin
      if (wr && we[k]) begin
        mem[b][8*k +: 8] = dq[8*k +: 8];
        mem[b][DATA_W+k] = pi[k];
      end
    end
    drv = (ds || wr) ? 1'b0 : (prd | drv);
    n1 <= n1v; sel <= sv; ps <= pv; cs <= cv; burst_advance_n <= av; gw <= gv; bw <= bv;
    lw <= lv; a <= adr; oe <= ov; zz <= slp; dq <= $random(seed); pi <= 4'($random(seed));
    #1;
    `CHK(crd, rdn)
    `CHK(cwe, wr ? we : 4'h0)
    if (rdn || wr) `CHK(ca, b)
    if (wr) `CHK({cwp, cwd}, dw)
    if (prd) `CHK({pa_o, dq_o}, pw)
    `CHK({oe_o, poe_o}, {2{!(drv && !oe && !slp)}})
    prd = rdn;
    if (rdn) pw = mem[b];
  endtask : step

  task automatic results();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hee0b;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      bs = ADDR_W'($random(seed));
      md <= m[0];
      step(0, 1, 1, 0, 1, 0, 1, 4'hf, bs, 1);
      repeat (3) step(0, 1, 1, 1, 0, 0, 1, 4'hf, bs, 0);
      step(0, 1, 1, 0, 1, 1, 0, 4'($random(seed)) | {4{m[0]}}, bs, 1);
      step(0, 1, 1, 1, 1, 1, 0, 4'($random(seed)), bs, 1);
      step(0, 1, 0, 1, 1, 0, 0, 4'h0, bs, 0);
      step(0, 1, 1, 1, 1, 1, 0, 4'($random(seed)), bs, 1);
      repeat (3) step(0, 1, 1, 1, 0, 1, 1, 4'hf, bs, 0);
      step(0, 1, 0, 1, 0, 1, 1, 4'hf, bs ^ 1, 0);
      step(0, 1, 1, 1, 0, 1, 1, 4'hf, bs, 0);
      step(m[0], 0, m[0], 0, 1, 1, 1, 4'hf, bs, 0);
      step(0, 1, 1, 1, 0, 1, 1, 4'hf, bs, 0);
    end
    step(0, 1, 0, 1, 0, 1, 1, 4'hf, bs, 0);
    repeat (2) step(0, 1, 1, 1, 0, 1, 1, 4'hf, bs, 0);
    step(1, 0, 1, 0, 1, 1, 1, 4'hf, bs, 0);
    slp = 1'b1;
    step(1, 0, 1, 1, 1, 1, 1, 4'hf, bs, 0);
    n = 0;
    while (n < 4 && so !== 1'b1) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK(32'(n), 32'd2)
    @(posedge clk_in);
    zz <= 1'b0;
    @(posedge clk_in);
    #1;
    `CHK(so, 1'b1)
    @(posedge clk_in);
    #1;
    `CHK(so, 1'b0)
    results();
  end
endmodule : test_psb_sram_decode
`default_nettype wire
